// >>> hdl/esp_top.sv
/*
  Line output block: each camera connector line carries either the gated strobe
  trigger or a timed exposure-end pulse, configured over APB.
  Assumes exposure_done and strobe_req are synchronous to pclk, one bit per
  physical connector line.
*/
// The address map and the APB slave port were decided locally.
// Function
// RULE1 - one common select: strobe or exposure-end
// RULE2 - exposure-end delay 0..1000 us, 10 us steps
// RULE3 - exposure-end width 40..10000 us, default 5000
// RULE4 - polarity: positive rises, negative falls
// RULE5 - no-camera option lets strobe reach empty lines
// RULE6 - every HDR image gets its own pulse
// RULE7 - every live frame gets its own pulse
// RULE8 - select common to lines, no-camera per line
// RULE9 - lines follow connector number, up to 8
// RULE10 - small variant has only lines 0..3
// RULE11 - controller waits for pulse end before next capture
// RULE12 - overlapping exposure end is ignored, pulse completes
`timescale 1ns/1ps
`default_nettype none
`include "esp_defines.svh"
module esp_top
  import esp_pkg::*;
#(
  parameter int NUM_LINES = 8,
  parameter int STEP_CYC = `ESP_STEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_LINES-1:0] exposure_done,
  input wire logic [NUM_LINES-1:0] strobe_req,
  input wire logic [NUM_LINES-1:0] camera_present,
  output logic [NUM_LINES-1:0] line_out
);
  localparam int SW = `ESP_STEPS_W;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  // out-of-range settings saturate rather than wrap, so a bad write
  // never yields a zero-width or very long pulse
  function automatic logic [SW-1:0] clamp_steps(input logic [31:0] v,
                                                input logic [31:0] lo,
                                                input logic [31:0] hi);
    logic [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r[SW-1:0];
  endfunction

  function automatic logic [15:0] count_ones(input logic [NUM_LINES-1:0] v);
    logic [15:0] n;
    n = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      n = n + 16'(v[i]);
    end
    return n;
  endfunction

  // --------------------------------------------------------------------------
  // apb slave: one wait state, read data registered
  // --------------------------------------------------------------------------
  logic ack_r;
  logic [31:0] prdata_r;
  logic access;
  logic wr_en;
  logic addr_ok;
  logic [31:0] rd_mux;

  esp_sel_e sel_r;
  logic pol_neg_r;
  logic [NUM_LINES-1:0] nocam_r;
  logic [SW-1:0] delay_r;
  logic [SW-1:0] width_r;
  logic [NUM_LINES-1:0] overlap_r;
  logic [15:0] pcount_r;
  logic [NUM_LINES-1:0] active;
  logic [NUM_LINES-1:0] busy;
  logic [NUM_LINES-1:0] dropped;
  logic [NUM_LINES-1:0] issued;
  logic [NUM_LINES-1:0] strobe_gated;
  logic [NUM_LINES-1:0] exposure_end_out;
  logic [NUM_LINES-1:0] strobe_trigger_out;
  logic [NUM_LINES-1:0] line_out_r;

  assign access = psel && penable;
  assign wr_en = access && ack_r && pwrite;
  assign pready = ack_r;
  assign prdata = prdata_r;
  assign pslverr = ack_r && !addr_ok;

  always_comb begin
    addr_ok = 1'b1;
    unique case (paddr)
      `ESP_OFF_CTRL, `ESP_OFF_NOCAM, `ESP_OFF_DELAY, `ESP_OFF_WIDTH,
      `ESP_OFF_STATUS, `ESP_OFF_OVERLAP, `ESP_OFF_PCOUNT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      `ESP_OFF_CTRL: begin
        rd_mux[`ESP_CTRL_SEL_BIT] = (sel_r == ESP_SEL_EXP_END);
        rd_mux[`ESP_CTRL_POL_BIT] = pol_neg_r;
      end
      `ESP_OFF_NOCAM: rd_mux = 32'(nocam_r);
      `ESP_OFF_DELAY: rd_mux = 32'(delay_r);
      `ESP_OFF_WIDTH: rd_mux = 32'(width_r);
      `ESP_OFF_STATUS: begin
        rd_mux[`ESP_STAT_CAM_LSB +: 8] = 8'(camera_present);
        rd_mux[`ESP_STAT_BUSY_LSB +: 8] = 8'(busy);
        rd_mux[`ESP_STAT_LINE_LSB +: 8] = 8'(line_out_r);
      end
      `ESP_OFF_OVERLAP: rd_mux = 32'(overlap_r);
      `ESP_OFF_PCOUNT: rd_mux = 32'(pcount_r);
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access && !ack_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (access && !ack_r) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= ESP_SEL_STROBE;
      pol_neg_r <= 1'b0;
    end else if (wr_en && paddr == `ESP_OFF_CTRL && pstrb[0]) begin
      // a single select serves every line, so the two signals exclude
      // each other by construction
      sel_r <= pwdata[`ESP_CTRL_SEL_BIT] ? ESP_SEL_EXP_END : ESP_SEL_STROBE; // RULE1 RULE8
      pol_neg_r <= pwdata[`ESP_CTRL_POL_BIT]; // RULE4
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nocam_r <= NUM_LINES'(`ESP_RST_NOCAM);
    end else if (wr_en && paddr == `ESP_OFF_NOCAM) begin
      // one bit per line, only as many lines as the variant has
      nocam_r <= NUM_LINES'(merge_lanes(32'(nocam_r), pwdata, pstrb)); // RULE8 RULE10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_r <= SW'(`ESP_RST_DELAY);
    end else if (wr_en && paddr == `ESP_OFF_DELAY) begin
      delay_r <= clamp_steps(merge_lanes(32'(delay_r), pwdata, pstrb),
                             32'd0, 32'(`ESP_DELAY_MAX_STEPS)); // RULE2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_r <= SW'(`ESP_WIDTH_DEF_STEPS);
    end else if (wr_en && paddr == `ESP_OFF_WIDTH) begin
      width_r <= clamp_steps(merge_lanes(32'(width_r), pwdata, pstrb),
                             32'(`ESP_WIDTH_MIN_STEPS), 32'(`ESP_WIDTH_MAX_STEPS)); // RULE3
    end
  end

  // --------------------------------------------------------------------------
  // per-line sequencers, indexed by physical connector
  // --------------------------------------------------------------------------
  // each exposure_done pulse (each HDR sub-image, each live frame) starts
  // its own pulse; the capture side is expected to leave room between
  // them, otherwise the overlapping one is dropped and flagged in overlap_r
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line // RULE9
    esp_tmr_if #(.STEPS_W(SW)) tif ();

    esp_step_timer #(
      .STEP_CYC(STEP_CYC)
    ) u_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .tif(tif.tmr)
    );

    esp_line_fsm #(
      .STEPS_W(SW)
    ) u_fsm (
      .pclk(pclk),
      .presetn(presetn),
      .exp_enable(sel_r == ESP_SEL_EXP_END),
      .event_in(exposure_done[i]), // RULE6 RULE7 RULE11
      .delay_steps(delay_r),
      .width_steps(width_r),
      .active(active[i]),
      .busy(busy[i]),
      .dropped(dropped[i]),
      .issued(issued[i]),
      .tif(tif.fsm)
    );
  end

  // --------------------------------------------------------------------------
  // event bookkeeping
  // --------------------------------------------------------------------------
  // write-one-to-clear; a drop in the clearing cycle stays recorded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overlap_r <= '0;
    end else if (wr_en && paddr == `ESP_OFF_OVERLAP) begin
      overlap_r <= (overlap_r & ~NUM_LINES'(pwdata & {{8{pstrb[3]}}, {8{pstrb[2]}},
                   {8{pstrb[1]}}, {8{pstrb[0]}}})) | dropped; // RULE12
    end else begin
      overlap_r <= overlap_r | dropped; // RULE12
    end
  end

  // wraps silently; software takes differences
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcount_r <= '0;
    end else begin
      pcount_r <= pcount_r + count_ones(issued); // RULE6 RULE7
    end
  end

  // --------------------------------------------------------------------------
  // line drivers
  // --------------------------------------------------------------------------
  assign strobe_gated = strobe_req & (camera_present | nocam_r); // RULE5
  assign strobe_trigger_out = strobe_gated;
  assign exposure_end_out = active ^ {NUM_LINES{pol_neg_r}}; // RULE4

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_out_r <= '0;
    end else if (sel_r == ESP_SEL_EXP_END) begin
      line_out_r <= exposure_end_out; // RULE1
    end else begin
      line_out_r <= strobe_trigger_out; // RULE1 RULE5
    end
  end

  assign line_out = line_out_r;
endmodule
`default_nettype wire

// >>> hdl/esp_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the exposure-end
  and strobe line output block.
  Assumes a 200 MHz pclk and 32-bit APB word registers.
*/
`ifndef ESP_DEFINES_SVH
`define ESP_DEFINES_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define ESP_CLK_PERIOD_NS 5
`define ESP_STEP_NS 10000
`define ESP_STEP_CYC (`ESP_STEP_NS / `ESP_CLK_PERIOD_NS)
`define ESP_DELAY_MAX_US 1000
`define ESP_WIDTH_MIN_US 40
`define ESP_WIDTH_MAX_US 10000
`define ESP_WIDTH_DEF_US 5000
`define ESP_DELAY_MAX_STEPS (`ESP_DELAY_MAX_US * 1000 / `ESP_STEP_NS)
`define ESP_WIDTH_MIN_STEPS (`ESP_WIDTH_MIN_US * 1000 / `ESP_STEP_NS)
`define ESP_WIDTH_MAX_STEPS (`ESP_WIDTH_MAX_US * 1000 / `ESP_STEP_NS)
`define ESP_WIDTH_DEF_STEPS (`ESP_WIDTH_DEF_US * 1000 / `ESP_STEP_NS)
`define ESP_STEPS_W 10

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define ESP_OFF_CTRL 12'h000
`define ESP_OFF_NOCAM 12'h004
`define ESP_OFF_DELAY 12'h008
`define ESP_OFF_WIDTH 12'h00C
`define ESP_OFF_STATUS 12'h010
`define ESP_OFF_OVERLAP 12'h014
`define ESP_OFF_PCOUNT 12'h018
`define ESP_CTRL_SEL_BIT 0
`define ESP_CTRL_POL_BIT 1
`define ESP_STAT_CAM_LSB 0
`define ESP_STAT_BUSY_LSB 8
`define ESP_STAT_LINE_LSB 16
`define ESP_RST_DELAY 0
`define ESP_RST_NOCAM 0

`endif

// >>> hdl/esp_pkg.sv
/*
  Types shared by the exposure-end and strobe line output block.
  Assumes nothing of its surroundings.
*/
package esp_pkg;
  typedef enum logic {
    ESP_SEL_STROBE,
    ESP_SEL_EXP_END
  } esp_sel_e;

  typedef enum logic [1:0] {
    ESP_ST_IDLE,
    ESP_ST_DELAY,
    ESP_ST_ACTIVE
  } esp_state_e;
endpackage

// >>> hdl/esp_tmr_if.sv
/*
  Carrier between a line sequencer and its 10 us step timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface esp_tmr_if #(
  parameter int STEPS_W = 10
);
  logic load;
  logic [STEPS_W-1:0] steps;
  logic expired;

  modport fsm (output load, output steps, input expired);
  modport tmr (input load, input steps, output expired);
endinterface
`default_nettype wire

// >>> hdl/esp_step_timer.sv
/*
  Step timer: counts a loaded number of 10 us steps exactly, in pclk cycles.
  Assumes load is a one-cycle strobe; a load restarts the count at once.
*/
`timescale 1ns/1ps
`default_nettype none
module esp_step_timer #(
  parameter int STEP_CYC = 2000
) (
  input wire logic pclk,
  input wire logic presetn,
  esp_tmr_if.tmr tif
);
  localparam int PW = $clog2(STEP_CYC);
  localparam logic [PW-1:0] PRE_TOP = PW'(STEP_CYC - 1);

  logic [$bits(tif.steps)-1:0] cnt_r;
  logic [PW-1:0] pre_r;
  logic busy_r;

  // the last cycle of the last step
  assign tif.expired = busy_r && (pre_r == '0) && (cnt_r == 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      pre_r <= '0;
    end else if (tif.load) begin
      busy_r <= (tif.steps != '0);
      cnt_r <= tif.steps;
      pre_r <= PRE_TOP;
    end else if (busy_r) begin
      if (pre_r == '0) begin
        pre_r <= PRE_TOP;
        if (cnt_r == 1) begin
          busy_r <= 1'b0;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end else begin
        pre_r <= pre_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/esp_line_fsm.sv
/*
  Exposure-end pulse sequencer for one output line: delay, then active width.
  Assumes event_in is a one-cycle pulse per finished exposure.
*/
`timescale 1ns/1ps
`default_nettype none
module esp_line_fsm
  import esp_pkg::*;
#(
  parameter int STEPS_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic exp_enable,
  input wire logic event_in,
  input wire logic [STEPS_W-1:0] delay_steps,
  input wire logic [STEPS_W-1:0] width_steps,
  output logic active,
  output logic busy,
  output logic dropped,
  output logic issued,
  esp_tmr_if.fsm tif
);
  esp_state_e state_r;
  logic [STEPS_W-1:0] width_hold_r;
  logic take;

  assign take = event_in && exp_enable && (state_r == ESP_ST_IDLE);
  assign active = (state_r == ESP_ST_ACTIVE);
  assign busy = (state_r != ESP_ST_IDLE);
  // a pending or running pulse finishes unchanged
  assign dropped = event_in && exp_enable && busy; // RULE12
  assign issued = (take && delay_steps == '0) ||
                  (state_r == ESP_ST_DELAY && tif.expired);

  always_comb begin
    tif.load = 1'b0;
    tif.steps = width_hold_r;
    if (take) begin
      tif.load = 1'b1;
      tif.steps = (delay_steps == '0) ? width_steps : delay_steps; // RULE2
    end else if (state_r == ESP_ST_DELAY && tif.expired) begin
      tif.load = 1'b1; // RULE3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_hold_r <= '0;
    end else if (take) begin
      width_hold_r <= width_steps;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ESP_ST_IDLE;
    end else begin
      unique case (state_r)
        ESP_ST_IDLE: begin
          if (take) begin
            state_r <= (delay_steps == '0) ? ESP_ST_ACTIVE : ESP_ST_DELAY;
          end
        end
        ESP_ST_DELAY: begin
          if (tif.expired) begin
            state_r <= ESP_ST_ACTIVE;
          end
        end
        ESP_ST_ACTIVE: begin
          if (tif.expired) begin
            state_r <= ESP_ST_IDLE;
          end
        end
        default: begin
          state_r <= ESP_ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/esp_line_observer.sv
/*
  Far-side observer: times every pulse on the output lines as an
  external strobe controller would see them.
  Assumes one pclk domain and idle level given by neg_pol.
*/
`timescale 1ns/1ps
`default_nettype none
module esp_line_observer (
  input wire logic pclk,
  input wire logic [7:0] line_out,
  input wire logic neg_pol,
  output int cyc,
  output int ends [8],
  output int start [8],
  output int len [8]
);
  logic [7:0] prev_r = 8'h00;
  logic [7:0] act;
  assign act = line_out ^ {8{neg_pol}};
  initial begin
    cyc = 0;
    foreach (ends[i]) begin
      ends[i] = 0;
      start[i] = 0;
      len[i] = 0;
    end
  end
  // a pulse is counted only when it ends, so a reader sees complete figures
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    prev_r <= act;
    for (int i = 0; i < 8; i++) begin
      if (act[i] && !prev_r[i]) start[i] <= cyc;
      if (!act[i] && prev_r[i]) begin
        len[i] <= cyc - start[i];
        ends[i] <= ends[i] + 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/esp_top_assertions.sv
/*
  Port-level checker of the line output block.
  Assumes shadows of the config built from full-word APB writes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "esp_defines.svh"
module esp_top_assertions #(
  parameter int NUM_LINES = 8,
  parameter int STEP_CYC = 2000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_LINES-1:0] exposure_done,
  input wire logic [NUM_LINES-1:0] strobe_req,
  input wire logic [NUM_LINES-1:0] camera_present,
  input wire logic [NUM_LINES-1:0] line_out
);
  logic wr_ok, sel_r, pol_r;
  logic [NUM_LINES-1:0] nocam_r;
  logic [9:0] dly_r, wid_r;
  logic [15:0] since_r, hi_r;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  // -------------------------
  // config shadow and counters
  // -------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= 1'b0;
      pol_r <= 1'b0;
      nocam_r <= '0;
      dly_r <= 10'h000;
      wid_r <= 10'h1f4;
    end else if (wr_ok) begin
      if (paddr == `ESP_OFF_CTRL) begin
        sel_r <= pwdata[0];
        pol_r <= pwdata[1];
      end
      if (paddr == `ESP_OFF_NOCAM) nocam_r <= pwdata[NUM_LINES-1:0];
      if (paddr == `ESP_OFF_DELAY) dly_r <= (pwdata > 100) ? 10'h064 : pwdata[9:0];
      if (paddr == `ESP_OFF_WIDTH) begin
        wid_r <= (pwdata < 4) ? 10'h004 : (pwdata > 1000) ? 10'h3e8 : pwdata[9:0];
      end
    end
  end
  // saturates so a long idle spell never wraps into a false match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_r <= 16'hffff;
    else if (exposure_done[0]) since_r <= 16'h0000;
    else if (since_r != 16'hffff) since_r <= since_r + 16'h0001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_r <= 16'h0000;
    else if (line_out[0]) hi_r <= hi_r + 16'h0001;
    else hi_r <= 16'h0000;
  end
  // -------------------------
  // properties
  // -------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  strobe_gate_a: assert property (!$past(sel_r) |->
    line_out == $past(strobe_req & (camera_present | nocam_r))) else $error("strobe gating wrong");
  delay_exact_a: assert property (sel_r && !pol_r && $rose(line_out[0]) |->
    since_r == dly_r * STEP_CYC + 1) else $error("pulse delay wrong");
  width_exact_a: assert property (sel_r && !pol_r && $fell(line_out[0]) |->
    hi_r == wid_r * STEP_CYC) else $error("pulse width wrong");
  neg_delay_a: assert property (sel_r && pol_r && $fell(line_out[0]) |->
    since_r == dly_r * STEP_CYC + 1) else $error("negative pulse start wrong");
  overlap_hold_a: assert property (sel_r && !pol_r && line_out[0] && exposure_done[0]
    && hi_r < wid_r * STEP_CYC - 4 |=> line_out[0] [*3]) else $error("overlap cut pulse");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  wait_state_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("answer timing wrong");
  cover property (exposure_done[0] && line_out[0]);
  cover property (pslverr);
  cover property (sel_r && pol_r && $fell(line_out[0]));
endmodule
bind esp_top esp_top_assertions #(.NUM_LINES(NUM_LINES), .STEP_CYC(STEP_CYC))
  esp_top_assertions_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .exposure_done(exposure_done), .strobe_req(strobe_req),
  .camera_present(camera_present), .line_out(line_out));
`default_nettype wire

// >>> tb/esp_top_bench.sv
/*
  Self-checking bench of the line output block, STEP_CYC 4.
  Assumes the observer model on the output lines.
*/
`timescale 1ns/1ps
`default_nettype none
`include "esp_defines.svh"
module esp_top_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, neg_pol, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [7:0] exposure_done, strobe_req, camera_present, line_out;
  int bad_count, samples_checked, cyc, ev, e0, n0;
  int ends [8];
  int start [8];
  int len [8];
  esp_top #(.NUM_LINES(8), .STEP_CYC(4)) esp_top_i (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exposure_done(exposure_done), .strobe_req(strobe_req),
    .camera_present(camera_present), .line_out(line_out));
  esp_line_observer esp_line_observer_i (.pclk(pclk), .line_out(line_out),
    .neg_pol(neg_pol), .cyc(cyc), .ends(ends), .start(start), .len(len));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // -------------------------
  // tasks
  // -------------------------
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) bad_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, err);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, q, err);
    chk(q, e);
  endtask
  task fire(input int i);
    @(posedge pclk);
    exposure_done <= 8'h01 << i;
    @(negedge pclk) ev = cyc;
    @(posedge pclk);
    exposure_done <= 8'h00;
  endtask
  // the next exposure is held back until the pulse has ended
  task wait_end(input int i, input int n);
    int k;
    k = 0;
    while (ends[i] == n && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(ends[i] - n), 32'h0000_0001);
  endtask
  // delay 2 steps of 4 cycles plus 2 register cycles (state_r, line_out_r); width 4 steps
  task pulse_chk(input int i, input int e);
    chk(32'(start[i] - e), 32'h0000_000a);
    chk(32'(len[i]), 32'h0000_0010);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    finish_test;
  end
  // -------------------------
  // tests
  // -------------------------
  initial begin
    {psel, penable, pwrite, neg_pol, paddr, pwdata} = '0;
    pstrb = 4'hf;
    {exposure_done, strobe_req, camera_present} = '0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ESP_OFF_CTRL, 32'h0000_0000);
    rd(`ESP_OFF_NOCAM, 32'h0000_0000);
    rd(`ESP_OFF_DELAY, 32'h0000_0000);
    rd(`ESP_OFF_WIDTH, 32'h0000_01f4);
    rd(12'h020, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    wr(`ESP_OFF_DELAY, 32'h0000_00c8);
    rd(`ESP_OFF_DELAY, 32'h0000_0064);
    wr(`ESP_OFF_WIDTH, 32'h0000_0001);
    rd(`ESP_OFF_WIDTH, 32'h0000_0004);
    wr(`ESP_OFF_DELAY, 32'h0000_0002);
    $display("test registers done");
    camera_present <= 8'h0f;
    strobe_req <= 8'hff;
    fire(0);
    repeat (30) @(posedge pclk);
    chk(32'(line_out), 32'h0000_000f);
    wr(`ESP_OFF_NOCAM, 32'h0000_0030);
    repeat (2) @(posedge pclk);
    chk(32'(line_out), 32'h0000_003f);
    rd(`ESP_OFF_PCOUNT, 32'h0000_0000);
    strobe_req <= 8'h00;
    $display("test strobe done");
    wr(`ESP_OFF_CTRL, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      n0 = ends[i];
      fire(i);
      wait_end(i, n0);
      pulse_chk(i, ev);
    end
    n0 = ends[0];
    fire(0);
    e0 = ev;
    repeat (12) @(posedge pclk);
    fire(0);
    wait_end(0, n0);
    pulse_chk(0, e0);
    repeat (40) @(posedge pclk);
    chk(32'(ends[0] - n0), 32'h0000_0001);
    rd(`ESP_OFF_OVERLAP, 32'h0000_0001);
    wr(`ESP_OFF_OVERLAP, 32'h0000_0001);
    rd(`ESP_OFF_OVERLAP, 32'h0000_0000);
    rd(`ESP_OFF_PCOUNT, 32'h0000_0004);
    $display("test exposure end done");
    wr(`ESP_OFF_CTRL, 32'h0000_0003);
    repeat (3) @(posedge pclk);
    chk(32'(line_out), 32'h0000_00ff);
    neg_pol <= 1'b1;
    repeat (2) @(posedge pclk);
    n0 = ends[0];
    fire(0);
    wait_end(0, n0);
    pulse_chk(0, ev);
    $display("test polarity done");
    finish_test;
  end
endmodule
`default_nettype wire
